// file: design/pdm_clkdiv.sv
`timescale 1ns/1ps
module pdm_clkdiv
  import pdm_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic run,
  input wire logic [2:0] sel,
  // enable pulse
  output logic tick
);

  logic [3:0] cnt_reg;
  logic [3:0] last;

  // terminal count per clock select code
  always_comb begin
    if (sel == CLK_DIV8) begin
      last = DIV8_LAST;
    end else if (sel == CLK_DIV16) begin
      last = DIV16_LAST;
    end else begin
      last = DIV1_LAST;
    end
  end

  // divider, stopped while clocks are halted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 4'h0;
      tick <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 4'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      tick <= 1'b0;
    end
  end

endmodule

// file: design/pdm_pkg.sv
package pdm_pkg;

  // ----
  // register map
  // ----
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SYSCTL1 = 8'h00;
  localparam logic [7:0] OFS_SYSCTL2 = 8'h04;
  localparam logic [7:0] OFS_MSTBY1 = 8'h08;
  localparam logic [7:0] OFS_MSTBY2 = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ----
  // field positions
  // ----
  localparam int SC1_STBY_BIT = 7;
  localparam int SC1_WAIT_LSB = 4;
  localparam int SC2_SLP_BIT = 7;
  localparam int SC2_DIR_BIT = 5;
  localparam int SC2_CLK_LSB = 2;
  localparam int MS1_SCI_BIT = 5;
  localparam int MS1_ADC_BIT = 4;
  localparam int MS1_WDT_BIT = 3;
  localparam int MS1_TMW_BIT = 2;
  localparam int MS1_TMV_BIT = 1;
  localparam int MS2_SCI2_BIT = 7;
  localparam int STAT_ST_LSB = 0;
  localparam int STAT_CLK_LSB = 3;
  localparam int STAT_OSC_BIT = 6;

  // ----
  // reset values and writable bits
  // ----
  localparam logic [7:0] SC1_RST = 8'h00;
  localparam logic [7:0] SC2_RST = 8'h00;
  localparam logic [7:0] MS1_RST = 8'h00;
  localparam logic [7:0] MS2_RST = 8'h00;
  localparam logic [7:0] SC1_MASK = 8'hf0;
  localparam logic [7:0] SC2_MASK = 8'hbc;
  localparam logic [7:0] MS1_MASK = 8'h3e;
  localparam logic [7:0] MS2_MASK = 8'h80;

  // ----
  // clock select codes and timing counts
  // ----
  localparam logic [2:0] CLK_DIV8 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [3:0] DIV1_LAST = 4'h0;
  localparam logic [3:0] DIV8_LAST = 4'h7;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam int WAIT_W = 20;
  localparam int WAIT_BASE_DEF = 1024;

  // ----
  // types
  // ----
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_SUBSLEEP = 3'b011,
    ST_STANDBY = 3'b100,
    ST_SETTLE = 3'b101,
    ST_LOCKED = 3'b110
  } pdm_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } ahb_req_s;

  typedef struct packed {
    logic tmv;
    logic tmw;
    logic wdt;
    logic adc;
    logic sci;
    logic sci2;
  } module_run_s;

  typedef struct packed {
    logic tmv;
    logic adc;
    logic sci;
    logic sci2;
  } module_rst_s;

endpackage

// file: design/pdm_sync.sv
`timescale 1ns/1ps
module pdm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // raw and filtered level
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // three stage chain, s1 feeds only s2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // output follows once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dout <= RST_VAL;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// file: design/power_down_mode_controller.sv
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - halt picks sleep, subsleep, standby or direct move from three bits
// - a transition with sleep select set resets timer V, serial units, converter
// - sleep halts the cpu; peripherals run at the selected clock
// - an interrupt in sleep returns to active with exception handling
// - masked or disabled interrupts do not end sleep
// - reset pin low in sleep puts the cpu in reset
// - standby stops the clock generator, cpu and peripherals
// - standby floats all port outputs, contents kept
// - standby wake restarts the clock, waits the settling time, then interrupts
// - masked or disabled interrupts do not end standby
// - after settling and pin release, reset exception handling starts
// - subsleep halts the oscillator, cpu and peripherals, ports kept
// - unmasked enabled interrupt ends subsleep after the wait time
// - a new clock select takes effect only at the next halt
// - halt with direct flag stays active at new rate, direct exception starts
// - direct interrupt disabled sends the chip to sleep instead
// - direct move with mask set gives sleep that no interrupt ends
// - module standby bit set stops that module clock, clear restores it
// - second module standby register: bit 7 second serial unit, rest read 0
// - subsleep and standby hold timer V, serial, converter in reset
// - in standby watchdog may run; timer W counts from the subclock
// - clock select 0xx undivided, 100 eighth, 101 sixteenth
module power_down_mode_controller
  import pdm_pkg::*;
#(
  parameter int IRQ_N = 8,
  parameter int WAIT_BASE = WAIT_BASE_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu and interrupt logic
  input wire logic halt_exec,
  input wire logic ccr_imask,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic [IRQ_N-1:0] irq_en,
  input wire logic direct_irq_en,
  // pins and peripheral clock source selects
  input wire logic reset_pin_n,
  input wire logic wdt_int_osc_sel,
  input wire logic tmw_internal_clk_sel,
  // cpu control
  output logic cpu_halt,
  output logic cpu_reset,
  output logic irq_exc_start,
  output logic direct_exc_start,
  output logic reset_exc_start,
  // clocking and peripherals
  output logic osc_run,
  output logic port_hiz,
  output logic periph_tick,
  output module_run_s mod_run,
  output module_rst_s mod_rst,
  output logic tmw_subclk,
  output logic [2:0] mode_state
);

  // ----
  // declarations
  // ----
  pdm_state_e state_reg;
  pdm_state_e state_next;
  ahb_req_s dph_reg;
  logic [7:0] sc1_reg;
  logic [7:0] sc2_reg;
  logic [7:0] ms1_reg;
  logic [7:0] ms2_reg;
  logic [2:0] clk_applied_reg;
  logic [WAIT_W-1:0] wait_reg;
  logic pin_n_s;
  logic accept;
  logic wake;
  logic load_wait;
  logic fire_irq;
  logic fire_dir;
  logic fire_rst;
  logic apply_clk;
  logic sel_xfer;
  logic clk_run;
  logic standby_select;
  logic sleep_select;
  logic direct_transfer_flag;
  logic [2:0] active_clock_select;
  logic [2:0] wake_wait_time;

  // settling count for a wait time code
  function automatic logic [WAIT_W-1:0] wait_load(input logic [2:0] code);
    logic [WAIT_W-1:0] base;
    base = WAIT_W'(WAIT_BASE);
    return base << code;
  endfunction

  // register read decode
  function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      OFS_SYSCTL1: v = sc1_reg;
      OFS_SYSCTL2: v = sc2_reg;
      OFS_MSTBY1: v = ms1_reg;
      OFS_MSTBY2: v = ms2_reg;
      OFS_STATUS: begin
        v[STAT_ST_LSB +: 3] = state_reg;
        v[STAT_CLK_LSB +: 3] = clk_applied_reg;
        v[STAT_OSC_BIT] = osc_run;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----
  // inputs and fields
  // ----
  pdm_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(reset_pin_n),
    .dout(pin_n_s)
  );

  // control fields out of the system control registers
  assign standby_select = sc1_reg[SC1_STBY_BIT];
  assign wake_wait_time = sc1_reg[SC1_WAIT_LSB +: 3];
  assign sleep_select = sc2_reg[SC2_SLP_BIT];
  assign direct_transfer_flag = sc2_reg[SC2_DIR_BIT];
  assign active_clock_select = sc2_reg[SC2_CLK_LSB +: 3];

  assign wake = (|(irq_req & irq_en)) & !ccr_imask;

  // ----
  // ahb-lite slave
  // ----
  assign accept = hsel & htrans[1] & hready;

  // address phase capture, cleared when the data phase ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_reg <= '0;
    end else if (accept) begin
      dph_reg <= '{valid: 1'b1, write: hwrite, addr: haddr[ADDR_W-1:0]};
    end else if (hready) begin
      dph_reg.valid <= 1'b0;
    end
  end

  // one wait state on reads, writes complete at once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= !(accept & !hwrite);
      hresp <= 1'b0;
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (dph_reg.valid & !dph_reg.write & !hreadyout) begin
      hrdata <= {24'h00_0000, reg_read(dph_reg.addr)};
    end
  end

  // register writes, reserved bits forced to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sc1_reg <= SC1_RST;
      sc2_reg <= SC2_RST;
      ms1_reg <= MS1_RST;
      ms2_reg <= MS2_RST;
    end else if (state_reg == ST_RESET) begin
      sc1_reg <= SC1_RST;
      sc2_reg <= SC2_RST;
      ms1_reg <= MS1_RST;
      ms2_reg <= MS2_RST;
    end else if (dph_reg.valid & dph_reg.write & hready) begin
      case (dph_reg.addr)
        OFS_SYSCTL1: sc1_reg <= hwdata[7:0] & SC1_MASK;
        OFS_SYSCTL2: sc2_reg <= hwdata[7:0] & SC2_MASK;
        OFS_MSTBY1: ms1_reg <= hwdata[7:0] & MS1_MASK;
        OFS_MSTBY2: ms2_reg <= hwdata[7:0] & MS2_MASK;
        default: ;
      endcase
    end
  end

  // ----
  // mode sequencer
  // ----
  always_comb begin
    state_next = state_reg;
    load_wait = 1'b0;
    fire_irq = 1'b0;
    fire_dir = 1'b0;
    fire_rst = 1'b0;
    apply_clk = 1'b0;
    sel_xfer = 1'b0;
    if (!pin_n_s) begin
      state_next = ST_RESET;
      // clock restarts while pin held low
      if ((state_reg == ST_STANDBY) || (state_reg == ST_SUBSLEEP)) begin
        load_wait = 1'b1;
      end
    end else begin
      case (state_reg)
        ST_RESET: begin
          if (wait_reg == '0) begin
            state_next = ST_ACTIVE;
            fire_rst = 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (halt_exec) begin
            apply_clk = 1'b1;
            sel_xfer = sleep_select;
            if (direct_transfer_flag) begin
              if (ccr_imask) begin
                state_next = ST_LOCKED;
              end else if (!direct_irq_en) begin
                state_next = ST_SLEEP;
              end else begin
                fire_dir = 1'b1;
              end
            end else if (standby_select) begin
              state_next = ST_STANDBY;
            end else if (sleep_select) begin
              state_next = ST_SUBSLEEP;
            end else begin
              state_next = ST_SLEEP;
            end
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            state_next = ST_ACTIVE;
            fire_irq = 1'b1;
          end
        end
        ST_SUBSLEEP, ST_STANDBY: begin
          if (wake) begin
            state_next = ST_SETTLE;
            load_wait = 1'b1;
          end
        end
        ST_SETTLE: begin
          if (wait_reg == '0) begin
            state_next = ST_ACTIVE;
            fire_irq = 1'b1;
          end
        end
        ST_LOCKED: state_next = ST_LOCKED;
        default: state_next = ST_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_reg <= '0;
    end else if (load_wait) begin
      wait_reg <= wait_load(wake_wait_time);
    end else if (wait_reg != '0) begin
      wait_reg <= wait_reg - WAIT_W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_applied_reg <= 3'h0;
    end else if (apply_clk) begin
      clk_applied_reg <= active_clock_select;
    end
  end

  // ----
  // clocks and peripheral control
  // ----
  // peripherals clocked in active, sleep and locked sleep
  assign clk_run = (state_next == ST_ACTIVE) || (state_next == ST_SLEEP) ||
                   (state_next == ST_LOCKED);

  pdm_clkdiv u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(clk_run),
    .sel(clk_applied_reg),
    .tick(periph_tick)
  );

  // cpu control and exception starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_halt <= 1'b0;
      cpu_reset <= 1'b1;
      irq_exc_start <= 1'b0;
      direct_exc_start <= 1'b0;
      reset_exc_start <= 1'b0;
      mode_state <= ST_RESET;
    end else begin
      cpu_halt <= (state_next != ST_ACTIVE) && (state_next != ST_RESET);
      cpu_reset <= state_next == ST_RESET;
      irq_exc_start <= fire_irq;
      direct_exc_start <= fire_dir;
      reset_exc_start <= fire_rst;
      mode_state <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_run <= 1'b1;
      port_hiz <= 1'b0;
    end else begin
      osc_run <= (state_next != ST_STANDBY) && (state_next != ST_SUBSLEEP);
      port_hiz <= state_next == ST_STANDBY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_run <= '0;
      tmw_subclk <= 1'b0;
    end else begin
      mod_run.tmv <= clk_run & !ms1_reg[MS1_TMV_BIT];
      mod_run.adc <= clk_run & !ms1_reg[MS1_ADC_BIT];
      mod_run.sci <= clk_run & !ms1_reg[MS1_SCI_BIT];
      mod_run.sci2 <= clk_run & !ms2_reg[MS2_SCI2_BIT];
      mod_run.wdt <= (clk_run & !ms1_reg[MS1_WDT_BIT]) | wdt_int_osc_sel;
      mod_run.tmw <= (clk_run & !ms1_reg[MS1_TMW_BIT]) |
                     ((state_next == ST_STANDBY) & tmw_internal_clk_sel);
      tmw_subclk <= (state_next == ST_STANDBY) & tmw_internal_clk_sel;
    end
  end

  // reset pulse on sleep select transition
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_rst <= '1;
    end else begin
      mod_rst <= {4{sel_xfer || (state_next == ST_SUBSLEEP) ||
                    (state_next == ST_STANDBY) || (state_next == ST_SETTLE) ||
                    (state_next == ST_RESET)}};
    end
  end

endmodule

// file: test/pdm_checker_asserts.sv
`timescale 1ns/1ps
module pdm_checker
  import pdm_pkg::*;
#(
  parameter int IRQ_N = 8,
  parameter int WAIT_BASE = WAIT_BASE_DEF
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // cpu and interrupt inputs
  input wire logic halt_exec,
  input wire logic ccr_imask,
  input wire logic [IRQ_N-1:0] irq_req,
  input wire logic [IRQ_N-1:0] irq_en,
  input wire logic reset_pin_n,
  // mode outputs
  input wire logic cpu_halt,
  input wire logic cpu_reset,
  input wire logic irq_exc_start,
  input wire logic direct_exc_start,
  input wire logic reset_exc_start,
  input wire logic osc_run,
  input wire logic port_hiz,
  input wire module_rst_s mod_rst,
  input wire logic [2:0] mode_state
);
  logic wake;
  logic steady;
  logic [2:0] pin_hi;
  int settle_cnt;
  // unmasked enabled request, pin high long enough to pass the sync
  assign wake = (|(irq_req & irq_en)) && !ccr_imask;
  assign steady = reset_pin_n && (pin_hi == 3'h7);
  // samples with the pin high, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_hi <= 3'h0;
    end else if (!reset_pin_n) begin
      pin_hi <= 3'h0;
    end else if (pin_hi != 3'h7) begin
      pin_hi <= pin_hi + 3'h1;
    end
  end
  // length of the current settle stay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_cnt <= 0;
    end else if (mode_state == ST_SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end else begin
      settle_cnt <= 0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  halt_pick_a: assert property (
    mode_state == ST_ACTIVE && halt_exec && steady |=> (cpu_halt && mode_state != ST_ACTIVE)
    or (mode_state == ST_ACTIVE ##[0:1] direct_exc_start)) else $error("halt gave no mode");
  sleep_wake_a: assert property (
    mode_state == ST_SLEEP && wake && steady |=> mode_state == ST_ACTIVE && irq_exc_start
    && !cpu_halt) else $error("sleep did not wake");
  sleep_keep_a: assert property (
    mode_state == ST_SLEEP && !wake && steady |=> mode_state == ST_SLEEP && cpu_halt)
    else $error("sleep left without wake");
  locked_keep_a: assert property (
    mode_state == ST_LOCKED && steady |=> mode_state == ST_LOCKED && !irq_exc_start)
    else $error("locked sleep left");
  deep_keep_a: assert property (
    mode_state inside {ST_SUBSLEEP, ST_STANDBY} && !wake && steady |=> $stable(mode_state))
    else $error("deep mode left without wake");
  deep_wake_a: assert property (
    mode_state inside {ST_SUBSLEEP, ST_STANDBY} && wake && steady |=> mode_state == ST_SETTLE
    && osc_run && !irq_exc_start) else $error("deep wake not settling");
  standby_pins_a: assert property (
    mode_state == ST_STANDBY |-> port_hiz && !osc_run && cpu_halt && mod_rst == 4'hf)
    else $error("standby outputs wrong");
  subsleep_pins_a: assert property (
    mode_state == ST_SUBSLEEP |-> !osc_run && !port_hiz && cpu_halt && mod_rst == 4'hf)
    else $error("subsleep outputs wrong");
  settle_time_a: assert property (
    irq_exc_start && $past(mode_state) == ST_SETTLE |-> settle_cnt >= WAIT_BASE)
    else $error("settle too short");
  reset_hold_a: assert property (
    !reset_pin_n && mode_state inside {ST_ACTIVE, ST_SLEEP, ST_LOCKED} ##1 !reset_pin_n [*4]
    |=> mode_state == ST_RESET && cpu_reset) else $error("pin low did not reset");
  reset_exit_a: assert property (
    reset_exc_start |-> osc_run && $past(reset_pin_n) && $past(reset_pin_n, 2) && !cpu_halt)
    else $error("reset exit before pin high");
  direct_pulse_a: assert property (
    direct_exc_start |-> mode_state == ST_ACTIVE && !cpu_halt ##1 !direct_exc_start)
    else $error("direct pulse wrong");
endmodule

// file: test/pdm_cpu_model.sv
`timescale 1ns/1ps
module pdm_cpu_model #(
  parameter int IRQ_N = 8
) (
  // clock
  input wire logic hclk,
  // design status seen by the cpu
  input wire logic irq_exc_start,
  input wire logic osc_run,
  // cpu and interrupt controller lines
  output logic halt_exec,
  output logic ccr_imask,
  output logic [IRQ_N-1:0] irq_req,
  output logic [IRQ_N-1:0] irq_en,
  output logic direct_irq_en,
  output logic reset_pin_n
);
  int ack_dly;
  // idle cpu, no requests, pin released
  initial begin
    halt_exec = 1'b0;
    ccr_imask = 1'b0;
    irq_req = '0;
    irq_en = '0;
    direct_irq_en = 1'b0;
    reset_pin_n = 1'b1;
    ack_dly = 0;
  end
  // halt instruction, one cycle wide
  task automatic halt();
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
  endtask
  // mask bit, requests and enables
  task automatic set_irq(input logic m, input logic [IRQ_N-1:0] r,
      input logic [IRQ_N-1:0] e, input logic d);
    ccr_imask <= m;
    irq_req <= r;
    irq_en <= e;
    direct_irq_en <= d;
  endtask
  // request withdrawn once taken, promptly or late
  always @(posedge hclk) begin
    if (irq_exc_start === 1'b1) begin
      repeat (ack_dly) @(posedge hclk);
      irq_req <= '0;
    end
  end
  task automatic pin_reset(input int hold);
    int n;
    reset_pin_n <= 1'b0;
    repeat (hold) @(posedge hclk);
    for (n = 0; n < 64 && osc_run !== 1'b1; n++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    reset_pin_n <= 1'b1;
  endtask
endmodule

// file: test/test_power_down_mode_controller.sv
`timescale 1ns/1ps
module test_power_down_mode_controller;
  import pdm_pkg::*;
  localparam int WB = 2;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, mode_state;
  logic halt_exec, ccr_imask, direct_irq_en, reset_pin_n, wdt_int_osc_sel, tmw_internal_clk_sel;
  logic [7:0] irq_req, irq_en;
  logic cpu_halt, cpu_reset, irq_exc_start, direct_exc_start, reset_exc_start;
  logic osc_run, port_hiz, periph_tick, tmw_subclk;
  module_run_s mod_run;
  module_rst_s mod_rst;
  int fail_count, check_count, i, n;
  logic [2:0] codes [3] = '{3'h4, 3'h5, 3'h0};
  int ticks [3] = '{4, 2, 32};
  // 10 MHz clock, bus hready from the one slave
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  assign hready = hreadyout;
  logic [2:0] pulses;
  assign pulses = {reset_exc_start, direct_exc_start, irq_exc_start};
  power_down_mode_controller #(.IRQ_N(8), .WAIT_BASE(WB)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata,
    .hreadyout, .hresp, .halt_exec, .ccr_imask, .irq_req, .irq_en, .direct_irq_en,
    .reset_pin_n, .wdt_int_osc_sel, .tmw_internal_clk_sel, .cpu_halt, .cpu_reset,
    .irq_exc_start, .direct_exc_start, .reset_exc_start, .osc_run, .port_hiz, .periph_tick,
    .mod_run, .mod_rst, .tmw_subclk, .mode_state);
  pdm_cpu_model #(.IRQ_N(8)) cpu (
    .hclk, .irq_exc_start, .osc_run, .halt_exec, .ccr_imask, .irq_req, .irq_en,
    .direct_irq_en, .reset_pin_n);
  // ----
  // checks and verdict
  // ----
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  // ----
  // ahb-lite master
  // ----
  task automatic wait_rdy();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // ----
  // mode helpers
  // ----
  function automatic logic [31:0] stv(input logic [2:0] c, input logic [2:0] s);
    return {25'h0, 1'b1, c, s};
  endfunction
  task automatic wait_st(input logic [2:0] s, input int lim);
    for (n = 0; n < lim && mode_state !== s; n++) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, s});
    if (mode_state !== s) print_verdict();
  endtask
  // cycles until a pulse: 0 interrupt, 1 direct, 2 reset exception
  task automatic wait_pulse(input int k, input int lim);
    for (n = 0; n < lim && pulses[k] !== 1'b1; n++) @(posedge hclk);
    if (pulses[k] !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic cnt_ticks(input int cyc, input int exp);
    int t;
    t = 0;
    repeat (cyc) begin
      @(posedge hclk);
      if (periph_tick === 1'b1) t++;
    end
    chk(t, exp);
  endtask
  // settle wait in cycles counted from the wake request
  task automatic chk_wait(input int w);
    chk({31'h0, n >= w + 1 && n <= w + 4}, 32'h1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    wdt_int_osc_sel = 1'b0;
    tmw_internal_clk_sel = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wait_st(ST_ACTIVE, 20);
    for (i = 0; i < 4; i++) rdc(8'(i * 4), 32'h0);
    rdc(OFS_STATUS, stv(3'h0, ST_ACTIVE));
    wr(OFS_MSTBY2, 32'hff);
    rdc(OFS_MSTBY2, 32'h80);
    wr(8'h20, 32'hff);
    rdc(8'h20, 32'h0);
    wr(OFS_MSTBY1, 32'hff);
    rdc(OFS_MSTBY1, 32'h3e);
    chk({26'h0, mod_run}, 32'h0);
    wr(OFS_MSTBY1, 32'h0);
    wr(OFS_MSTBY2, 32'h0);
    rdc(OFS_MSTBY2, 32'h0);
    chk({26'h0, mod_run}, 32'h3f);
    wr(OFS_SYSCTL2, 32'h10);
    rdc(OFS_STATUS, stv(3'h0, ST_ACTIVE));
    // direct moves through each clock code
    for (i = 0; i < 3; i++) begin
      wr(OFS_SYSCTL2, {24'h0, 3'h1, codes[i], 2'h0});
      cpu.set_irq(1'b0, 8'h0, 8'h0, 1'b1);
      cpu.halt();
      wait_pulse(1, 4);
      rdc(OFS_STATUS, stv(codes[i], ST_ACTIVE));
      cnt_ticks(32, ticks[i]);
    end
    // direct with its interrupt disabled falls to sleep
    cpu.set_irq(1'b0, 8'h0, 8'h0, 1'b0);
    cpu.halt();
    wait_st(ST_SLEEP, 3);
    chk({26'h0, mod_run}, 32'h3f);
    cnt_ticks(8, 8);
    cpu.set_irq(1'b1, 8'h01, 8'h01, 1'b0);
    repeat (4) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, ST_SLEEP});
    cpu.set_irq(1'b0, 8'h01, 8'h00, 1'b0);
    repeat (4) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, ST_SLEEP});
    cpu.set_irq(1'b0, 8'h01, 8'h01, 1'b0);
    wait_pulse(0, 4);
    wait_st(ST_ACTIVE, 3);
    // direct with the mask set locks sleep
    cpu.set_irq(1'b1, 8'h0, 8'h0, 1'b1);
    cpu.halt();
    wait_st(ST_LOCKED, 3);
    cpu.set_irq(1'b0, 8'h80, 8'h80, 1'b1);
    repeat (8) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, ST_LOCKED});
    fork
      cpu.pin_reset(8);
      begin
        repeat (7) @(posedge hclk);
        chk({28'h0, cpu_reset, mode_state}, {29'h1, ST_RESET});
      end
    join
    wait_pulse(2, 20);
    wait_st(ST_ACTIVE, 4);
    rdc(OFS_SYSCTL2, 32'h0);
    // subsleep with wait code 2
    cpu.set_irq(1'b0, 8'h0, 8'h0, 1'b0);
    wr(OFS_SYSCTL1, 32'h20);
    wr(OFS_SYSCTL2, 32'h80);
    cpu.halt();
    wait_st(ST_SUBSLEEP, 3);
    chk({26'h0, osc_run, port_hiz, mod_rst}, 32'h0f);
    cpu.set_irq(1'b1, 8'h01, 8'h01, 1'b0);
    repeat (6) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, ST_SUBSLEEP});
    cpu.set_irq(1'b0, 8'h01, 8'h01, 1'b0);
    wait_pulse(0, 40);
    chk_wait(WB << 2);
    // standby with wait code 1, late request withdrawal
    cpu.ack_dly = 3;
    wdt_int_osc_sel <= 1'b1;
    tmw_internal_clk_sel <= 1'b1;
    wr(OFS_SYSCTL1, 32'h90);
    cpu.halt();
    wait_st(ST_STANDBY, 3);
    chk({28'h0, port_hiz, osc_run, tmw_subclk, mod_run.wdt}, 32'hb);
    cpu.set_irq(1'b0, 8'h01, 8'h00, 1'b0);
    repeat (6) @(posedge hclk);
    chk({29'h0, mode_state}, {29'h0, ST_STANDBY});
    cpu.set_irq(1'b0, 8'h01, 8'h01, 1'b0);
    wait_pulse(0, 40);
    chk_wait(WB << 1);
    wait_st(ST_ACTIVE, 4);
    // pin reset out of standby
    cpu.set_irq(1'b0, 8'h0, 8'h0, 1'b0);
    cpu.halt();
    wait_st(ST_STANDBY, 3);
    cpu.pin_reset(4);
    wait_pulse(2, 60);
    wait_st(ST_ACTIVE, 4);
    rdc(OFS_SYSCTL1, 32'h0);
    print_verdict();
  end
endmodule
bind power_down_mode_controller pdm_checker #(.IRQ_N(IRQ_N), .WAIT_BASE(WAIT_BASE)) u_chk (
  .hclk, .hresetn, .halt_exec, .ccr_imask, .irq_req, .irq_en, .reset_pin_n, .cpu_halt,
  .cpu_reset, .irq_exc_start, .direct_exc_start, .reset_exc_start, .osc_run, .port_hiz,
  .mod_rst, .mode_state);
